// ### rtl/read_pacer.sv
/*
 * one ddr read requester: splits a line into requests that never cross
 * a 256-byte boundary and keeps a minimum gap between request issues.
 * assumes the memory side answers with a ready level on the same clock.
 */
`include "vdma_regs.svh"

module read_pacer (
   input  wire logic                    clk_i,
   input  wire logic                    reset_n_i,
   input  wire logic                    line_go_i,
   input  wire vdma_pkg::line_cmd_t     line_cmd_i,
   input  wire logic [`GAP_CNT_W-1:0]   gap_i,
   input  wire logic                    buf_space_i,
   input  wire logic                    rd_ready_i,
   output logic                         rd_valid_o,
   output vdma_pkg::rd_req_t            rd_req_o,
   output logic                         line_busy_o,
   output logic                         line_done_o
);
   import vdma_pkg::*;

   pace_state_t               state_r;
   logic [`ADDR_W-1:0]        addr_r;
   logic [`LINE_BYTES_W-1:0]  remain_r;
   logic [`GAP_CNT_W-1:0]     gap_cnt_r;
   logic [`XFER_LEN_W-1:0]    to_boundary;
   logic [`XFER_LEN_W-1:0]    chunk_len;
   logic                      accept;
   logic                      issue;

   // bytes left before the next 256-byte boundary
   assign to_boundary = `BOUNDARY_BYTES - {1'b0, addr_r[`BOUNDARY_BITS-1:0]};
   // a chunk never runs past the line end, so lines never share a request
   assign chunk_len   = ({7'h00, remain_r} < {16'h0000, to_boundary}) ?
                        remain_r[`XFER_LEN_W-1:0] : to_boundary;
   assign accept      = rd_valid_o && rd_ready_i;
   // new request whenever no request is pending, buffer room exists, the gap has run out and bytes remain
   assign issue       = (state_r == PACE_LINE) && !rd_valid_o && (gap_cnt_r == '0) &&
                        buf_space_i && (remain_r != '0);

   // line walker and request register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r     <= PACE_IDLE;
         addr_r      <= '0;
         remain_r    <= '0;
         rd_valid_o  <= 1'b0;
         rd_req_o    <= '0;
         line_done_o <= 1'b0;
      end else begin
         line_done_o <= 1'b0;
         if (state_r == PACE_IDLE && line_go_i) begin
            state_r  <= PACE_LINE;
            addr_r   <= line_cmd_i.start_addr;
            remain_r <= line_cmd_i.line_bytes;
         end
         if (issue) begin
            rd_valid_o    <= 1'b1;
            rd_req_o.addr <= addr_r;
            rd_req_o.len  <= chunk_len;
            addr_r        <= addr_r + {23'h000000, chunk_len};
            remain_r      <= remain_r - {7'h00, chunk_len};
         end
         if (accept) begin
            rd_valid_o <= 1'b0;
            if (remain_r == '0) begin
               state_r     <= PACE_IDLE;
               line_done_o <= 1'b1;
            end
         end
         if (state_r == PACE_LINE && remain_r == '0 && !rd_valid_o && !issue) begin
            state_r     <= PACE_IDLE;       // zero-length line
            line_done_o <= 1'b1;
         end
      end
   end

   // gap counter: loaded when a request is issued, so the gap counts from the issue, stalled cycles included
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap_cnt_r <= '0;
      end else if (issue) begin
         gap_cnt_r <= gap_i;
      end else if (gap_cnt_r != '0) begin
         gap_cnt_r <= gap_cnt_r - 1'b1;
      end
   end

   assign line_busy_o = (state_r == PACE_LINE);

endmodule : read_pacer

// ### rtl/vdma_pkg.sv
/*
 * types shared by the video dma pacing and error block.
 * assumes vdma_regs.svh is on the include path.
 */
`include "vdma_regs.svh"

package vdma_pkg;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [`ADDR_W-1:0]       start_addr;
      logic [`LINE_BYTES_W-1:0] line_bytes;
   } line_cmd_t;

   typedef struct packed {
      logic [`ADDR_W-1:0]     addr;
      logic [`XFER_LEN_W-1:0] len;
   } rd_req_t;

   typedef struct packed {
      logic [`NUM_WBUF-1:0] wbuf_overflow;
      logic                 fault_pixel_read_error;
      logic                 dark_frame_read_error;
   } fail_flags_t;

   typedef struct packed {
      logic [`SYNC_CNT_W-1:0] line_length;
      logic [`SYNC_CNT_W-1:0] frame_lines;
      logic [`SYNC_CNT_W-1:0] sync_width;
   } frame_def_t;

   typedef enum logic [0:0] {
      PACE_IDLE = 1'b0,
      PACE_LINE = 1'b1
   } pace_state_t;

endpackage : vdma_pkg

// ### rtl/vdma_regs.svh
/*
 * constants for the video dma pacing and error block: field widths,
 * flag positions, reset values and timing counts.
 * assumes it is included by its bare name from rtl/.
 */
`ifndef VDMA_REGS_SVH
`define VDMA_REGS_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define CLK_PERIOD_NS        25
`define VP_BASE_DIV          2
`define RATE_SEL_W           4
`define RATE_SEL_RST         4'h0

// ************************************************************
// read requesters and spacing fields
// ************************************************************
`define NUM_REQ              3
`define REQ_PREVIEW          0
`define REQ_RESIZER          1
`define REQ_HISTOGRAM        2
`define GAP_FIELD_W          10
`define GAP_FIELD_MAX        10'h3ff
`define RESIZER_GAP_SHIFT    5
`define GAP_CNT_W            15
`define GAP_RST              10'h000

// ************************************************************
// ddr transfer geometry
// ************************************************************
`define ADDR_W               32
`define LINE_BYTES_W         16
`define XFER_LEN_W           9
`define BOUNDARY_BITS        8
`define BOUNDARY_BYTES       9'h100

// ************************************************************
// fail flags
// ************************************************************
`define NUM_WBUF             8
`define WBUF_SENSOR          0
`define WBUF_PREVIEW         1
`define WBUF_SCALER_L1       2
`define WBUF_SCALER_L2       3
`define WBUF_SCALER_L3       4
`define WBUF_SCALER_L4       5
`define WBUF_FOCUS           6
`define WBUF_EXPOSURE        7

// ************************************************************
// video port and sync generator
// ************************************************************
`define PIX_W                16
`define SYNC_CNT_W           13

`endif

// ### rtl/video_dma_pacing_and_errors.sv
/*
 * request pacing and fail flagging of the shared buffer logic: video port
 * rate divider, three paced ddr read requesters, sticky fail flags and
 * the line/frame sync master or slave logic.
 * assumes one 40 mhz clock (the sysclk/3 domain), software control on
 * plain ports, and sensor pixel data already on this clock.
 */
// Contract
// - no ddr request crosses a 256-byte boundary; requests at most 256 bytes.
// - each image line gets its own requests; lines never share one.
// - video port rate is independent of pixel clock, half rate out of reset.
// - rate select field slows new data to preview, statistics and histogram.
// - without throttling, data moves at the highest achievable rate.
// - ddr input is fetched at one unit per cycle unless throttled.
// - a ddr reader requests whenever its buffer has room, subject to spacing.
// - spacing fields set minimum cycles between reads for preview, resizer, histogram.
// - each spacing field accepts zero up to 1023.
// - resizer spacing field is multiplied by 32 before use.
// - each write buffer overflow sets its own fail flag.
// - missed fault pixel fetch deadline, while correction active, sets its flag.
// - missed dark-frame/shading read deadline, while active, sets its flag.
// - preview, statistics, histogram take raw data only; resizer takes ycc only.
// - master mode drives line/frame sync; slave mode follows external sync.
// - power and sleep controller reset clears the whole subsystem.
`include "vdma_regs.svh"

module video_dma_pacing_and_errors (
   input  wire logic                                 clk_i,
   input  wire logic                                 reset_n_i,
   // video port
   input  wire logic [`RATE_SEL_W-1:0]               video_port_rate_select_i,
   input  wire logic                                 format_config_ycc_i,
   input  wire logic                                 vp_pixel_valid_i,
   input  wire logic [`PIX_W-1:0]                    vp_pixel_i,
   output logic                                      raw_valid_o,
   output logic [`PIX_W-1:0]                         raw_pixel_o,
   output logic                                      ycc_valid_o,
   output logic [`PIX_W-1:0]                         ycc_pixel_o,
   // ddr read requesters
   input  wire logic [`GAP_FIELD_W-1:0]              read_request_spacing_preview_i,
   input  wire logic [`GAP_FIELD_W-1:0]              resizer_request_spacing_i,
   input  wire logic [`GAP_FIELD_W-1:0]              read_request_spacing_histogram_i,
   input  wire logic [`NUM_REQ-1:0]                  line_go_i,
   input  wire vdma_pkg::line_cmd_t [`NUM_REQ-1:0]   line_cmd_i,
   input  wire logic [`NUM_REQ-1:0]                  buf_space_i,
   input  wire logic [`NUM_REQ-1:0]                  rd_ready_i,
   output logic [`NUM_REQ-1:0]                       rd_valid_o,
   output vdma_pkg::rd_req_t [`NUM_REQ-1:0]          rd_req_o,
   output logic [`NUM_REQ-1:0]                       line_busy_o,
   output logic [`NUM_REQ-1:0]                       line_done_o,
   // error events and sticky flags
   input  wire logic [`NUM_WBUF-1:0]                 wbuf_overflow_i,
   input  wire logic                                 fault_pixel_active_i,
   input  wire logic                                 fault_pixel_deadline_miss_i,
   input  wire logic                                 dark_frame_active_i,
   input  wire logic                                 dark_frame_deadline_miss_i,
   input  wire vdma_pkg::fail_flags_t                fail_clear_i,
   output vdma_pkg::fail_flags_t                     subsystem_control_o,
   // sync pins
   input  wire logic                                 sync_master_i,
   input  wire vdma_pkg::frame_def_t                 frame_def_i,
   input  wire logic                                 line_sync_i,
   input  wire logic                                 frame_sync_i,
   output logic                                      line_sync_o,
   output logic                                      frame_sync_o,
   output logic                                      sync_oe_o,
   output logic                                      line_start_o,
   output logic                                      frame_start_o
);
   import vdma_pkg::*;

   // ************************************************************
   // video port rate
   // ************************************************************
   logic [`RATE_SEL_W:0]  vp_cnt_r;
   logic                  vp_tick;
   logic                  hold_valid_r;
   logic [`PIX_W-1:0]     hold_pix_r;

   // period is 2*(select+1) cycles; select 0 gives half rate, no pixel clock involved
   assign vp_tick = (vp_cnt_r == '0);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         vp_cnt_r <= '0;
      end else if (vp_tick) begin
         vp_cnt_r <= {video_port_rate_select_i, 1'b1};
      end else begin
         vp_cnt_r <= vp_cnt_r - 1'b1;
      end
   end

   // one-pixel holding stage; a second pixel before the tick overwrites it,
   // so sensor logic must not outpace the programmed rate
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_valid_r <= 1'b0;
         hold_pix_r   <= '0;
      end else if (vp_pixel_valid_i) begin
         hold_valid_r <= 1'b1;
         hold_pix_r   <= vp_pixel_i;
      end else if (vp_tick) begin
         hold_valid_r <= 1'b0;
      end
   end

   // route by format: raw consumers never see ycc and the resizer never sees raw
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         raw_valid_o <= 1'b0;
         ycc_valid_o <= 1'b0;
         raw_pixel_o <= '0;
         ycc_pixel_o <= '0;
      end else begin
         raw_valid_o <= vp_tick && hold_valid_r && !format_config_ycc_i;
         ycc_valid_o <= vp_tick && hold_valid_r && format_config_ycc_i;
         if (vp_tick && hold_valid_r) begin
            raw_pixel_o <= hold_pix_r;
            ycc_pixel_o <= hold_pix_r;
         end
      end
   end

   // ************************************************************
   // ddr read pacing
   // ************************************************************
   logic [`NUM_REQ-1:0][`GAP_CNT_W-1:0] gap;

   // fields are 10 bits wide so 0..1023 is the whole range; resizer scaled by 32
   assign gap[`REQ_PREVIEW]   = {5'h00, read_request_spacing_preview_i};
   assign gap[`REQ_RESIZER]   = {resizer_request_spacing_i, 5'h00};
   assign gap[`REQ_HISTOGRAM] = {5'h00, read_request_spacing_histogram_i};

   // zero spacing runs the requesters flat out, which is the default priority
   genvar g;
   generate
      for (g = 0; g < `NUM_REQ; g = g + 1) begin : g_req
         read_pacer u_pacer (
            .clk_i       (clk_i),
            .reset_n_i   (reset_n_i),
            .line_go_i   (line_go_i[g]),
            .line_cmd_i  (line_cmd_i[g]),
            .gap_i       (gap[g]),
            .buf_space_i (buf_space_i[g]),
            .rd_ready_i  (rd_ready_i[g]),
            .rd_valid_o  (rd_valid_o[g]),
            .rd_req_o    (rd_req_o[g]),
            .line_busy_o (),
            .line_done_o (line_done_o[g])
         );
      end
   endgenerate

   // busy rebuilt from line_go_i and line_done_o in a flop so the top output comes from a register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_busy_o <= '0;
      end else begin
         line_busy_o <= (line_busy_o | line_go_i) & ~line_done_o;
      end
   end

   // ************************************************************
   // sticky fail flags
   // ************************************************************
   fail_flags_t set_ev;
   fail_flags_t flags_nxt;

   assign set_ev.wbuf_overflow          = wbuf_overflow_i;
   assign set_ev.fault_pixel_read_error = fault_pixel_active_i &&
                                          fault_pixel_deadline_miss_i;
   assign set_ev.dark_frame_read_error  = dark_frame_active_i &&
                                          dark_frame_deadline_miss_i;
   // set wins over a clear landing in the same cycle
   assign flags_nxt = set_ev | (subsystem_control_o & ~fail_clear_i);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         subsystem_control_o <= '0;
      end else begin
         subsystem_control_o <= flags_nxt;
      end
   end

   // ************************************************************
   // line and frame sync
   // ************************************************************
   logic [1:0]              ls_sync_r;
   logic [1:0]              fs_sync_r;
   logic                    ls_prev_r;
   logic                    fs_prev_r;
   logic [`SYNC_CNT_W-1:0]  pix_cnt_r;
   logic [`SYNC_CNT_W-1:0]  line_cnt_r;
   logic                    line_end;
   logic                    frame_end;
   logic                    ls_eff;
   logic                    fs_eff;

   // pins come from another domain: two flops before any use
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ls_sync_r <= '0;
         fs_sync_r <= '0;
      end else begin
         ls_sync_r <= {ls_sync_r[0], line_sync_i};
         fs_sync_r <= {fs_sync_r[0], frame_sync_i};
      end
   end

   assign line_end  = (pix_cnt_r  >= frame_def_i.line_length - 1'b1);
   assign frame_end = (line_cnt_r >= frame_def_i.frame_lines - 1'b1);

   // master timing from the programmed frame definition
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pix_cnt_r  <= '0;
         line_cnt_r <= '0;
      end else if (!sync_master_i || line_end) begin
         pix_cnt_r  <= '0;
         if (!sync_master_i || frame_end) begin
            line_cnt_r <= '0;
         end else begin
            line_cnt_r <= line_cnt_r + 1'b1;
         end
      end else begin
         pix_cnt_r <= pix_cnt_r + 1'b1;
      end
   end

   // effective sync level: generated in master mode, followed in slave mode
   assign ls_eff = sync_master_i ? (pix_cnt_r  < frame_def_i.sync_width) : ls_sync_r[1];
   assign fs_eff = sync_master_i ? (line_cnt_r < frame_def_i.sync_width) : fs_sync_r[1];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_sync_o   <= 1'b0;
         frame_sync_o  <= 1'b0;
         sync_oe_o     <= 1'b0;
         ls_prev_r     <= 1'b0;
         fs_prev_r     <= 1'b0;
         line_start_o  <= 1'b0;
         frame_start_o <= 1'b0;
      end else begin
         line_sync_o   <= sync_master_i && ls_eff;
         frame_sync_o  <= sync_master_i && fs_eff && ls_eff;
         sync_oe_o     <= sync_master_i;
         ls_prev_r     <= ls_eff;
         fs_prev_r     <= fs_eff;
         line_start_o  <= ls_eff && !ls_prev_r;
         frame_start_o <= fs_eff && !fs_prev_r;
      end
   end

endmodule : video_dma_pacing_and_errors

// ### verification/ddr_read_model.sv
/*
 * ddr read side model: accepts paced read requests promptly or with stalls.
 * assumes requests are held until accepted.
 */
module ddr_read_model (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   output logic      [2:0] rd_ready_o
);
   timeunit 1ns;
   timeprecision 100ps;
   integer seed = 7;
   // random stalls make the pacer hold its requests
   always @(posedge clk_i) begin
      rd_ready_o <= slow_i ? 3'($random(seed)) : 3'h7;
   end
endmodule : ddr_read_model

// ### verification/test_video_dma_pacing_and_errors.sv
/*
 * testbench: line splits, gaps, fail flags, video port pace and sync drive.
 * assumes the design, checker and ddr model are compiled before it.
 */
module test_video_dma_pacing_and_errors;
   timeunit 1ns;
   timeprecision 100ps;
   import vdma_pkg::*;
   logic            clk = 0, rst_n = 0, pv = 0, ycc = 0, slow = 0, act = 0;
   logic            raw_v, ycc_v, soe, lso;
   logic [3:0]      sel = 0;
   logic [15:0]     pix = 0, raw_p, ycc_p;
   logic [9:0]      gp = 0, gr = 0, gh = 0, ev = 0;
   logic [2:0]      go = 0, space = 3'h7, rdy, vld, done;
   line_cmd_t [2:0] cmd = '0;
   rd_req_t [2:0]   req;
   fail_flags_t     clr = '0, flg;
   logic [31:0]     na [3];
   int              rem [3], took, r, err_count = 0, checks_done = 0;
   integer          seed = 32'h92287b5f;
   video_dma_pacing_and_errors i_video_dma_pacing_and_errors (.clk_i(clk), .reset_n_i(rst_n),
      .video_port_rate_select_i(sel), .format_config_ycc_i(ycc), .vp_pixel_valid_i(pv),
      .vp_pixel_i(pix), .raw_valid_o(raw_v), .raw_pixel_o(raw_p), .ycc_valid_o(ycc_v),
      .ycc_pixel_o(ycc_p), .read_request_spacing_preview_i(gp), .resizer_request_spacing_i(gr),
      .read_request_spacing_histogram_i(gh), .line_go_i(go), .line_cmd_i(cmd),
      .buf_space_i(space), .rd_ready_i(rdy), .rd_valid_o(vld), .rd_req_o(req),
      .line_busy_o(), .line_done_o(done), .wbuf_overflow_i(ev[9:2]),
      .fault_pixel_active_i(act), .fault_pixel_deadline_miss_i(ev[1]),
      .dark_frame_active_i(act), .dark_frame_deadline_miss_i(ev[0]), .fail_clear_i(clr),
      .subsystem_control_o(flg), .sync_master_i(1'b1), .frame_def_i({13'h10, 13'h8, 13'h2}),
      .line_sync_i(1'b0), .frame_sync_i(1'b0), .line_sync_o(lso), .frame_sync_o(),
      .sync_oe_o(soe), .line_start_o(), .frame_start_o());
   ddr_read_model i_ddr_read_model (.clk_i(clk), .slow_i(slow), .rd_ready_o(rdy));
   // ****************
   // checking helpers
   // ****************
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) space <= slow ? 3'($random(seed)) : 3'h7;
   task automatic chk(input string what, input logic [40:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   // each accepted request must be the next boundary-limited piece of the line
   always @(posedge clk) begin : mon
      int m;
      for (int i = 0; i < 3; i++) begin
         if (vld[i] === 1'b1 && rdy[i] === 1'b1) begin
            m = 256 - na[i][7:0];
            if (rem[i] < m) m = rem[i];
            chk("request", {na[i], 9'(m)}, req[i]);
            na[i] += m;
            rem[i] -= m;
         end
         if (done[i] === 1'b1) chk("line bytes left", 0, rem[i]);
      end
   end
   task automatic run_line(input int q, input logic [31:0] a, input int b);
      @(posedge clk);
      na[q] = a;
      rem[q] = b;
      cmd[q] <= '{a, 16'(b)};
      go[q] <= 1'b1;
      @(posedge clk);
      go[q] <= 1'b0;
      took = 0;
      while (done[q] !== 1'b1 && took < 9000) begin
         @(posedge clk);
         took++;
      end
      chk("line done", 1, done[q]);
   endtask : run_line
   // count port pulses over forty rate periods with a pixel always waiting
   task automatic vp_run(input logic [3:0] s, input logic y);
      int nr, ny;
      @(posedge clk);
      sel <= s;
      ycc <= y;
      pv <= 1'b1;
      pix <= 16'($random(seed));
      repeat (40) @(posedge clk);
      nr = 0;
      ny = 0;
      repeat (80 * (s + 1)) begin
         @(posedge clk);
         nr += raw_v;
         ny += ycc_v;
      end
      chk("port pace", 1, (y ? ny : nr) inside {[39:41]});
      chk("port route", 0, y ? nr : ny);
      chk("port pixel", pix, y ? ycc_p : raw_p);
   endtask : vp_run
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("flags after reset", 0, flg);
      chk("sync drive", 1, soe);
      took = 0;
      repeat (16) @(posedge clk) took += lso;
      chk("line sync width", 2, took);
      run_line(0, 32'h80, 32'h200);
      run_line(0, 32'h0, 32'h400);
      chk("back to back", 1, took <= 12);
      gp <= 10'h3ff;
      run_line(0, 32'h0, 32'h200);
      chk("preview gap", 1, took >= 1023);
      gr <= 10'h001;
      run_line(1, 32'h0, 32'h200);
      chk("resizer gap", 1, took >= 32);
      $display("test lines done");
      slow <= 1'b1;
      repeat (12) begin
         r = $unsigned($random(seed)) % 3;
         gp <= 10'($random(seed)) & 10'h3;
         gr <= 10'($random(seed)) & 10'h1;
         gh <= 10'($random(seed)) & 10'h7;
         run_line(r, $random(seed) & 32'h0fffffe0, 32 * (1 + $unsigned($random(seed)) % 32));
      end
      slow <= 1'b0;
      $display("test random lines done");
      act <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         ev <= 10'h1 << i;
         @(posedge clk);
         ev <= 10'h0;
         @(posedge clk);
         chk("flag set", 10'h1 << i, flg);
         repeat (3) @(posedge clk);
         chk("flag held", 10'h1 << i, flg);
         clr <= 10'h1 << i;
         @(posedge clk);
         clr <= '0;
         @(posedge clk);
         chk("flag cleared", 0, flg);
      end
      act <= 1'b0;
      ev <= 10'h003;
      @(posedge clk);
      ev <= 10'h3fc;
      @(posedge clk);
      ev <= 10'h0;
      @(posedge clk);
      chk("inactive misses", 10'h3fc, flg);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("flags after reset", 0, flg);
      $display("test flags done");
      for (int k = 0; k < 4; k++) vp_run(k == 0 ? 4'h0 : 4'($random(seed)) & 4'h7, k[0]);
      $display("test video port done");
      conclude();
   end
   initial begin
      #(25 * 40000);
      err_count++;
      conclude();
   end
endmodule : test_video_dma_pacing_and_errors

// ### verification/video_dma_pacing_and_errors_properties.sv
/*
 * checker for the pacing and fail flag block: request split, hold, gaps, flags.
 * assumes only the top module's ports are visible; bound below.
 */
`include "vdma_regs.svh"
module vdma_checker (
   input wire logic                          clk_i,
   input wire logic                          reset_n_i,
   input wire logic [`GAP_FIELD_W-1:0]       read_request_spacing_preview_i,
   input wire logic [`GAP_FIELD_W-1:0]       resizer_request_spacing_i,
   input wire logic [`NUM_REQ-1:0]           rd_ready_i,
   input wire logic [`NUM_REQ-1:0]           rd_valid_o,
   input wire vdma_pkg::rd_req_t [`NUM_REQ-1:0] rd_req_o,
   input wire logic [`NUM_WBUF-1:0]          wbuf_overflow_i,
   input wire logic                          fault_pixel_active_i,
   input wire logic                          fault_pixel_deadline_miss_i,
   input wire logic                          dark_frame_active_i,
   input wire logic                          dark_frame_deadline_miss_i,
   input wire vdma_pkg::fail_flags_t         fail_clear_i,
   input wire vdma_pkg::fail_flags_t         subsystem_control_o
);
   import vdma_pkg::*;
   // ****************
   // gap counters
   // ****************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [`GAP_CNT_W-1:0] pv_idle_r;
   logic [`GAP_CNT_W-1:0] rs_idle_r;
   logic [1:0]            vld_prev_r;
   // count idle cycles owed after each issued preview and resizer request (rise of valid)
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pv_idle_r  <= '0;
         rs_idle_r  <= '0;
         vld_prev_r <= '0;
      end else begin
         vld_prev_r <= rd_valid_o[1:0];
         pv_idle_r <= (rd_valid_o[0] & !vld_prev_r[0]) ? 15'(read_request_spacing_preview_i)
                    : pv_idle_r - 15'(pv_idle_r != 0);
         rs_idle_r <= (rd_valid_o[1] & !vld_prev_r[1]) ? {resizer_request_spacing_i, 5'h00}
                    : rs_idle_r - 15'(rs_idle_r != 0);
      end
   end
   // ****************
   // properties
   // ****************
   sequence s_req_wait;
      rd_valid_o[0] && !rd_ready_i[0];
   endsequence
   property p_no_cross;
      rd_valid_o[0] |-> rd_req_o[0].len != 0
         && (9'(rd_req_o[0].addr[7:0]) + rd_req_o[0].len) <= `BOUNDARY_BYTES;
   endproperty
   property p_req_hold;
      s_req_wait |=> rd_valid_o[0] && $stable(rd_req_o[0]);
   endproperty
   property p_pv_gap;
      pv_idle_r != 0 |-> !rd_valid_o[0] || vld_prev_r[0];
   endproperty
   property p_rs_gap;
      rs_idle_r != 0 |-> !rd_valid_o[1] || vld_prev_r[1];
   endproperty
   property p_wbuf_set;
      |wbuf_overflow_i |=> &(subsystem_control_o.wbuf_overflow | ~$past(wbuf_overflow_i));
   endproperty
   property p_fault_set;
      fault_pixel_active_i && fault_pixel_deadline_miss_i |=> subsystem_control_o[1];
   endproperty
   property p_dark_set;
      dark_frame_active_i && dark_frame_deadline_miss_i |=> subsystem_control_o[0];
   endproperty
   property p_sticky;
      reset_n_i |=> ($past(subsystem_control_o) & ~$past(fail_clear_i)
                    & ~subsystem_control_o) == 10'h000;
   endproperty
   a_no_cross: assert property (p_no_cross)
      else $error("read request crosses a boundary");
   a_req_hold: assert property (p_req_hold)
      else $error("read request dropped or changed before ready");
   a_pv_gap: assert property (p_pv_gap)
      else $error("preview request inside its gap");
   a_rs_gap: assert property (p_rs_gap)
      else $error("resizer request inside its gap");
   a_wbuf_set: assert property (p_wbuf_set)
      else $error("overflow flag not set");
   a_fault_set: assert property (p_fault_set)
      else $error("fault pixel flag not set");
   a_dark_set: assert property (p_dark_set)
      else $error("dark frame flag not set");
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without clear");
endmodule : vdma_checker
bind video_dma_pacing_and_errors vdma_checker i_vdma_checker (.clk_i, .reset_n_i,
   .read_request_spacing_preview_i, .resizer_request_spacing_i, .rd_ready_i, .rd_valid_o,
   .rd_req_o, .wbuf_overflow_i, .fault_pixel_active_i, .fault_pixel_deadline_miss_i,
   .dark_frame_active_i, .dark_frame_deadline_miss_i, .fail_clear_i, .subsystem_control_o);
